/* verilog/msr_bank.sv */
/*
 motor status register bank top: AXI4-Lite slave, three read-only status
 words loaded by the motor core, and the device control word.
 assumes a single clock aclk and a synchronous active-low reset.
*/
// Chosen here: the AXI4-Lite slave port.
module msr_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [msr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [msr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic output_voltage_magnitude_we,
   input wire logic [15:0] output_voltage_magnitude,
   input wire logic param_we,
   input wire logic [7:0] measured_resistance,
   input wire logic [7:0] measured_back_emf_constant,
   input wire logic [7:0] measured_inductance,
   input wire logic meas_we,
   input wire logic resistance_step_status,
   input wire logic inductance_step_status,
   input wire logic back_emf_step_status,
   input wire logic mechanical_step_status,
   input wire logic [3:0] recommended_switching_frequency,
   input wire logic eeprom_done,
   input wire logic tickle_ack,
   output logic eeprom_write_request,
   output logic eeprom_read_request,
   output logic clear_faults,
   output logic clear_retry_count,
   output logic [7:0] eeprom_access_key,
   output logic [8:0] forced_align_angle,
   output logic watchdog_tickle
);
   ////////////////////////////////////////////////////////////////////////
   // status words

   logic [31:0] algo_word;
   logic [31:0] param_word;
   logic [31:0] meas_word;
   logic [31:0] ctrl_word;

   msr_upd_if algo_upd ();
   msr_upd_if param_upd ();
   msr_upd_if meas_upd ();
   msr_wr_if ctrl_wr ();

   assign algo_upd.we = output_voltage_magnitude_we;
   assign algo_upd.value = {output_voltage_magnitude, 16'h0000};
   assign param_upd.we = param_we;
   assign param_upd.value = {measured_resistance,
                             measured_back_emf_constant,
                             measured_inductance,
                             8'h00};
   assign meas_upd.we = meas_we;
   assign meas_upd.value = {resistance_step_status,
                            inductance_step_status,
                            back_emf_step_status,
                            mechanical_step_status,
                            recommended_switching_frequency,
                            24'h00_0000};

   msr_status_word #(.MASK(msr_pkg::ALGO_MASK)) u_algo (
      .aclk(aclk),
      .aresetn(aresetn),
      .upd(algo_upd.dst),
      .word(algo_word)
   );

   msr_status_word #(.MASK(msr_pkg::PARAM_MASK)) u_param (
      .aclk(aclk),
      .aresetn(aresetn),
      .upd(param_upd.dst),
      .word(param_word)
   );

   msr_status_word #(.MASK(msr_pkg::MEAS_MASK)) u_meas (
      .aclk(aclk),
      .aresetn(aresetn),
      .upd(meas_upd.dst),
      .word(meas_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order

   msr_pkg::msr_wr_state_t wr_state;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_mapped;

   assign s_axi_awready = !aw_held && (wr_state == msr_pkg::WR_ACCEPT);
   assign s_axi_wready = !w_held && (wr_state == msr_pkg::WR_ACCEPT);
   assign s_axi_bvalid = (wr_state == msr_pkg::WR_RESP);
   assign do_write = aw_held && w_held && (wr_state == msr_pkg::WR_ACCEPT);
   assign wr_mapped = (aw_idx == msr_pkg::IDX_ALGO) || (aw_idx == msr_pkg::IDX_PARAM) ||
                      (aw_idx == msr_pkg::IDX_MEAS) || (aw_idx == msr_pkg::IDX_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_idx <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_idx <= s_axi_awaddr[msr_pkg::ADDR_W-1:2];
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= msr_pkg::WR_ACCEPT;
      end else begin
         case (wr_state)
            msr_pkg::WR_ACCEPT: begin
               if (do_write) begin
                  wr_state <= msr_pkg::WR_RESP;
               end
            end
            msr_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= msr_pkg::WR_ACCEPT;
               end
            end
            default: begin
               wr_state <= msr_pkg::WR_ACCEPT;
            end
         endcase
      end
   end

   // unallocated offsets answer with an error and change nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= msr_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= wr_mapped ? msr_pkg::RESP_OKAY : msr_pkg::RESP_SLVERR;
      end
   end

   // only the control word listens; status writes are acknowledged and dropped
   assign ctrl_wr.we = do_write && (aw_idx == msr_pkg::IDX_CTRL);
   assign ctrl_wr.data = w_data;
   assign ctrl_wr.strb = w_strb;

   msr_ctrl_word u_ctrl (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(ctrl_wr.dst),
      .eeprom_done(eeprom_done),
      .tickle_ack(tickle_ack),
      .word(ctrl_word),
      .clear_faults(clear_faults),
      .clear_retry_count(clear_retry_count)
   );

   assign eeprom_write_request = ctrl_word[msr_pkg::EE_WR_BIT];
   assign eeprom_read_request = ctrl_word[msr_pkg::EE_RD_BIT];
   assign eeprom_access_key = ctrl_word[msr_pkg::KEY_LSB +: 8];
   assign forced_align_angle = ctrl_word[msr_pkg::ANGLE_LSB +: 9];
   assign watchdog_tickle = ctrl_word[msr_pkg::TICKLE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // read channel: one cycle from address to data

   logic [7:0] ar_idx;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   assign s_axi_arready = !s_axi_rvalid;
   assign ar_idx = s_axi_araddr[msr_pkg::ADDR_W-1:2];

   always_comb begin
      next_rresp = msr_pkg::RESP_OKAY;
      case (ar_idx)
         msr_pkg::IDX_ALGO: next_rdata = algo_word;
         msr_pkg::IDX_PARAM: next_rdata = param_word;
         msr_pkg::IDX_MEAS: next_rdata = meas_word;
         // write-only control fields read back as zero
         msr_pkg::IDX_CTRL: next_rdata = ctrl_word & msr_pkg::CTRL_RD_MASK;
         default: begin
            next_rdata = 32'h0000_0000;
            next_rresp = msr_pkg::RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= msr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_volt_update;
      @(posedge aclk) disable iff (!aresetn)
         output_voltage_magnitude_we |=> algo_word[msr_pkg::VOLT_LSB +: 16] == $past(output_voltage_magnitude);
   endproperty
   a_volt_update: assert property (p_volt_update)
      else $error("voltage magnitude not loaded");

   property p_algo_reset;
      @(posedge aclk) disable iff (!aresetn)
         $rose(aresetn) |-> algo_word == msr_pkg::RST_WORD;
   endproperty
   a_algo_reset: assert property (p_algo_reset)
      else $error("algorithm word not zero after reset");

   property p_param_reserved;
      @(posedge aclk) disable iff (!aresetn) param_word[7:0] == 8'h00;
   endproperty
   a_param_reserved: assert property (p_param_reserved)
      else $error("parameter reserved byte not zero");

   property p_res_field;
      @(posedge aclk) disable iff (!aresetn)
         param_we |=> param_word[msr_pkg::RES_LSB +: 8] == $past(measured_resistance);
   endproperty
   a_res_field: assert property (p_res_field)
      else $error("resistance field wrong");

   property p_bemf_field;
      @(posedge aclk) disable iff (!aresetn)
         param_we |=> param_word[msr_pkg::BEMF_LSB +: 8] == $past(measured_back_emf_constant);
   endproperty
   a_bemf_field: assert property (p_bemf_field)
      else $error("back-emf field wrong");

   property p_ind_field;
      @(posedge aclk) disable iff (!aresetn)
         param_we |=> param_word[msr_pkg::IND_LSB +: 8] == $past(measured_inductance);
   endproperty
   a_ind_field: assert property (p_ind_field)
      else $error("inductance field wrong");

   property p_meas_reserved;
      @(posedge aclk) disable iff (!aresetn) meas_word[23:0] == 24'h00_0000;
   endproperty
   a_meas_reserved: assert property (p_meas_reserved)
      else $error("measurement reserved bits not zero");

   property p_r_step;
      @(posedge aclk) disable iff (!aresetn)
         meas_we |=> meas_word[msr_pkg::R_STEP_BIT] == $past(resistance_step_status);
   endproperty
   a_r_step: assert property (p_r_step)
      else $error("resistance step bit wrong");

   property p_l_step;
      @(posedge aclk) disable iff (!aresetn)
         meas_we |=> meas_word[msr_pkg::L_STEP_BIT] == $past(inductance_step_status);
   endproperty
   a_l_step: assert property (p_l_step)
      else $error("inductance step bit wrong");

   property p_ke_step;
      @(posedge aclk) disable iff (!aresetn)
         meas_we |=> meas_word[msr_pkg::KE_STEP_BIT] == $past(back_emf_step_status);
   endproperty
   a_ke_step: assert property (p_ke_step)
      else $error("back-emf step bit wrong");

   property p_mech_step;
      @(posedge aclk) disable iff (!aresetn)
         meas_we |=> meas_word[msr_pkg::MECH_STEP_BIT] == $past(mechanical_step_status);
   endproperty
   a_mech_step: assert property (p_mech_step)
      else $error("mechanical step bit wrong");

   property p_freq_code;
      @(posedge aclk) disable iff (!aresetn)
         meas_we ##1 !meas_we [*2] |-> meas_word[msr_pkg::FREQ_LSB +: 4]
            == $past(recommended_switching_frequency, 2);
   endproperty
   a_freq_code: assert property (p_freq_code)
      else $error("frequency code not held");

   property p_ctrl_reset;
      @(posedge aclk) disable iff (!aresetn)
         $rose(aresetn) |-> ctrl_word == msr_pkg::RST_WORD;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("control word not zero after reset");

   property p_status_write_ignored;
      @(posedge aclk) disable iff (!aresetn)
         do_write && (aw_idx == msr_pkg::IDX_ALGO) && !output_voltage_magnitude_we |=> $stable(algo_word);
   endproperty
   a_status_write_ignored: assert property (p_status_write_ignored)
      else $error("bus write changed a status word");

   property p_read_latency;
      @(posedge aclk) disable iff (!aresetn)
         s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0
            (s_axi_rresp == msr_pkg::RESP_SLVERR) == ($past(ar_idx) != msr_pkg::IDX_ALGO &&
            $past(ar_idx) != msr_pkg::IDX_PARAM && $past(ar_idx) != msr_pkg::IDX_MEAS &&
            $past(ar_idx) != msr_pkg::IDX_CTRL);
   endproperty
   a_read_latency: assert property (p_read_latency)
      else $error("read answer late or wrong response");

   property p_write_resp;
      @(posedge aclk) disable iff (!aresetn) do_write |=> s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp)
      else $error("write response missing");
endmodule : msr_bank

/* verilog/msr_pkg.sv */
/*
 motor status register bank: shared constants, field layout and types.
 assumes the bank sits on an AXI4-Lite bus with 10-bit byte addresses.
*/
// Contract
// - volt magnitude in algorithm word bits 31-16
// - algorithm word at E4h, zero after reset
// - parameter word at E6h, zero, bits 7-0 reserved
// - parameter bits 31-24 give winding resistance
// - parameter bits 23-16 give back-emf constant
// - parameter bits 15-8 give winding inductance
// - measurement word at E8h, bits 23-0 reserved
// - measurement bit 31 is resistance step status
// - measurement bit 30 is inductance step status
// - measurement bit 29 is back-emf step status
// - measurement bit 28 is mechanical step status
// - measurement bits 27-24 give recommended frequency code
// - control word at EAh, resets to zero
package msr_pkg;
   localparam int ADDR_W = 10;
   // printed offsets are word indices; byte address is index times four
   localparam logic [7:0] IDX_ALGO = 8'he4;
   localparam logic [7:0] IDX_PARAM = 8'he6;
   localparam logic [7:0] IDX_MEAS = 8'he8;
   localparam logic [7:0] IDX_CTRL = 8'hea;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // full-scale code of the voltage magnitude (percent = code*100/32767)
   localparam logic [15:0] VOLT_FULL_SCALE = 16'h7fff;
   localparam int VOLT_LSB = 16;
   localparam int RES_LSB = 24;
   localparam int BEMF_LSB = 16;
   localparam int IND_LSB = 8;
   localparam int R_STEP_BIT = 31;
   localparam int L_STEP_BIT = 30;
   localparam int KE_STEP_BIT = 29;
   localparam int MECH_STEP_BIT = 28;
   localparam int FREQ_LSB = 24;
   localparam logic [31:0] ALGO_MASK = 32'hffff_0000;
   localparam logic [31:0] PARAM_MASK = 32'hffff_ff00;
   localparam logic [31:0] MEAS_MASK = 32'hff00_0000;
   // control word fields
   localparam int EE_WR_BIT = 31;
   localparam int EE_RD_BIT = 30;
   localparam int CLR_FLT_BIT = 29;
   localparam int CLR_RETRY_BIT = 28;
   localparam int KEY_LSB = 20;
   localparam int ANGLE_LSB = 11;
   localparam int TICKLE_BIT = 10;
   localparam logic [31:0] CTRL_STORE_MASK = 32'hcfff_fc00;
   localparam logic [31:0] CTRL_RD_MASK = 32'hc000_0400;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {WR_ACCEPT, WR_RESP} msr_wr_state_t;
endpackage : msr_pkg

/* verilog/msr_if.sv */
/*
 carriers between the bank top and its word modules.
 assumes both ends share aclk; no timing of their own.
*/
interface msr_upd_if;
   logic we;
   logic [31:0] value;
   modport src (output we, output value);
   modport dst (input we, input value);
endinterface : msr_upd_if

interface msr_wr_if;
   logic we;
   logic [31:0] data;
   logic [3:0] strb;
   modport src (output we, output data, output strb);
   modport dst (input we, input data, input strb);
endinterface : msr_wr_if

/* verilog/msr_status_word.sv */
/*
 one read-only status word, loaded by the motor core only.
 assumes the bus never reaches it; MASK clears reserved bits.
*/
module msr_status_word #(
   parameter logic [31:0] MASK = 32'hffff_ffff
) (
   input wire logic aclk,
   input wire logic aresetn,
   msr_upd_if.dst upd,
   output logic [31:0] word
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word <= msr_pkg::RST_WORD;
      end else if (upd.we) begin
         word <= upd.value & MASK;
      end
   end

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn) (word & ~MASK) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bits not zero");
endmodule : msr_status_word

/* verilog/msr_ctrl_word.sv */
/*
 device control word: stored bits, self-clearing command pulses.
 assumes the core acknowledges eeprom and watchdog requests by pulses.
*/
module msr_ctrl_word (
   input wire logic aclk,
   input wire logic aresetn,
   msr_wr_if.dst wr,
   input wire logic eeprom_done,
   input wire logic tickle_ack,
   output logic [31:0] word,
   output logic clear_faults,
   output logic clear_retry_count
);
   logic [31:0] byte_mask;
   logic [31:0] next_word;

   always_comb begin
      byte_mask = {{8{wr.strb[3]}}, {8{wr.strb[2]}}, {8{wr.strb[1]}}, {8{wr.strb[0]}}};
      next_word = word;
      // core clears first so a write in the same cycle wins
      if (eeprom_done) begin
         next_word[msr_pkg::EE_WR_BIT] = 1'b0;
         next_word[msr_pkg::EE_RD_BIT] = 1'b0;
      end
      if (tickle_ack) begin
         next_word[msr_pkg::TICKLE_BIT] = 1'b0;
      end
      if (wr.we) begin
         next_word = (next_word & ~byte_mask) | (wr.data & byte_mask);
      end
      next_word = next_word & msr_pkg::CTRL_STORE_MASK;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word <= msr_pkg::RST_WORD;
      end else begin
         word <= next_word;
      end
   end

   // command bits are never stored, only pulsed for one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_faults <= 1'b0;
         clear_retry_count <= 1'b0;
      end else begin
         clear_faults <= wr.we && wr.strb[3] && wr.data[msr_pkg::CLR_FLT_BIT];
         clear_retry_count <= wr.we && wr.strb[3] && wr.data[msr_pkg::CLR_RETRY_BIT];
      end
   end

   property p_clear_pulse;
      @(posedge aclk) disable iff (!aresetn) clear_faults |=> !clear_faults [*1];
   endproperty
   a_clear_pulse: assert property (p_clear_pulse)
      else $error("clear fault pulse longer than one cycle");
endmodule : msr_ctrl_word

/* testbench/tb_top.sv */
/*
 self-checking bench for the motor status register bank top.
 assumes the bank answers on AXI4-Lite and the core loads by we pulses.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic vm_we = 1'b0, pm_we = 1'b0, ms_we = 1'b0, ee_done = 1'b0, tk_ack = 1'b0;
   logic [15:0] vmag = '0;
   logic [7:0] res = '0, bemf = '0, ind = '0;
   logic [4:0] mflags = '0;
   logic [3:0] mfreq = '0;
   logic ee_wr, ee_rd, clr_f, clr_r, tickle;
   logic [7:0] key;
   logic [8:0] angle;
   int mismatches = 0, total_checks = 0, cycles = 0, cf_cnt = 0, cr_cnt = 0;
   localparam logic [9:0] A_ALGO = {msr_pkg::IDX_ALGO, 2'b00};
   localparam logic [9:0] A_PARAM = {msr_pkg::IDX_PARAM, 2'b00};
   localparam logic [9:0] A_MEAS = {msr_pkg::IDX_MEAS, 2'b00};
   localparam logic [9:0] A_CTRL = {msr_pkg::IDX_CTRL, 2'b00};

   msr_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .output_voltage_magnitude_we(vm_we), .output_voltage_magnitude(vmag), .param_we(pm_we),
      .measured_resistance(res), .measured_back_emf_constant(bemf),
      .measured_inductance(ind), .meas_we(ms_we), .resistance_step_status(mflags[4]),
      .inductance_step_status(mflags[3]), .back_emf_step_status(mflags[2]),
      .mechanical_step_status(mflags[1]), .recommended_switching_frequency(mfreq),
      .eeprom_done(ee_done), .tickle_ack(tk_ack), .eeprom_write_request(ee_wr),
      .eeprom_read_request(ee_rd), .clear_faults(clr_f), .clear_retry_count(clr_r),
      .eeprom_access_key(key), .forced_align_angle(angle), .watchdog_tickle(tickle));

   always #5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // hang guard: all tests finish well inside this
   always @(posedge aclk) begin
      cycles++;
      if (clr_f === 1'b1) cf_cnt++;
      if (clr_r === 1'b1) cr_cnt++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////////
   // bus master: hold each channel until its own ready is sampled high
   task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // one idle edge so a following call never re-raises bready in this step
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   task automatic rd_check(input string what, input logic [9:0] a, input logic [31:0] exp,
         input logic [1:0] exp_resp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      check(what, exp, d);
      check({what, " rresp"}, {30'h0, exp_resp}, {30'h0, r});
   endtask : rd_check

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      rd_check("algorithm word", A_ALGO, 32'h0, msr_pkg::RESP_OKAY);
      rd_check("parameter word", A_PARAM, 32'h0, msr_pkg::RESP_OKAY);
      rd_check("measurement word", A_MEAS, 32'h0, msr_pkg::RESP_OKAY);
      rd_check("control word", A_CTRL, 32'h0, msr_pkg::RESP_OKAY);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_algo_and_params;
      @(posedge aclk);
      vm_we <= 1'b1;
      vmag <= msr_pkg::VOLT_FULL_SCALE;
      pm_we <= 1'b1;
      res <= 8'h81;
      bemf <= 8'h3c;
      ind <= 8'he7;
      @(posedge aclk);
      vm_we <= 1'b0;
      pm_we <= 1'b0;
      vmag <= 16'h8001;
      rd_check("voltage magnitude", A_ALGO, 32'h7fff_0000, msr_pkg::RESP_OKAY);
      rd_check("motor parameters", A_PARAM, 32'h813c_e700, msr_pkg::RESP_OKAY);
      $display("test algo_and_params done");
   endtask : t_algo_and_params

   task automatic t_meas_flags;
      logic [4:0] f;
      for (int i = 0; i < 5; i++) begin
         f = (i < 4) ? 5'h10 >> i : 5'h1f;
         @(posedge aclk);
         ms_we <= 1'b1;
         mflags <= f;
         mfreq <= (i < 4) ? 4'(i * 5 + 1) : 4'hf;
         @(posedge aclk);
         ms_we <= 1'b0;
         mflags <= 5'h0;
         rd_check("measurement word", A_MEAS,
            {f[4:1], (i < 4) ? 4'(i * 5 + 1) : 4'hf, 24'h0}, msr_pkg::RESP_OKAY);
      end
      $display("test meas_flags done");
   endtask : t_meas_flags

   task automatic t_status_writes;
      logic [1:0] r;
      axi_wr(A_ALGO, 32'hffff_ffff, r);
      check("algorithm write bresp", 32'(msr_pkg::RESP_OKAY), 32'(r));
      axi_wr(A_PARAM, 32'h0000_00ff, r);
      check("parameter write bresp", 32'(msr_pkg::RESP_OKAY), 32'(r));
      axi_wr(A_MEAS, 32'h00ff_ffff, r);
      check("measurement write bresp", 32'(msr_pkg::RESP_OKAY), 32'(r));
      rd_check("algorithm after write", A_ALGO, 32'h7fff_0000, msr_pkg::RESP_OKAY);
      rd_check("parameter after write", A_PARAM, 32'h813c_e700, msr_pkg::RESP_OKAY);
      rd_check("measurement after write", A_MEAS, 32'hff00_0000, msr_pkg::RESP_OKAY);
      // unallocated offsets are only ever read, never written
      rd_check("unmapped read e5", 10'h394, 32'h0, msr_pkg::RESP_SLVERR);
      rd_check("unmapped read", 10'h39c, 32'h0, msr_pkg::RESP_SLVERR);
      $display("test status_writes done");
   endtask : t_status_writes

   task automatic t_control;
      logic [1:0] r;
      // every field set, including the dropped low bits
      axi_wr(A_CTRL, 32'hfa5d_9fff, r);
      check("control bresp", 32'(msr_pkg::RESP_OKAY), 32'(r));
      @(posedge aclk);
      check("clear faults pulses", 32'd1, 32'(cf_cnt));
      check("clear retry pulses", 32'd1, 32'(cr_cnt));
      check("request outputs", 32'h7, {29'h0, ee_wr, ee_rd, tickle});
      check("key and angle", 32'h0001_4bb3, {15'h0, key, angle});
      rd_check("control readback", A_CTRL, 32'hc000_0400, msr_pkg::RESP_OKAY);
      @(posedge aclk);
      ee_done <= 1'b1;
      tk_ack <= 1'b1;
      @(posedge aclk);
      ee_done <= 1'b0;
      tk_ack <= 1'b0;
      rd_check("control after acks", A_CTRL, 32'h0, msr_pkg::RESP_OKAY);
      check("requests after acks", 32'h0, {29'h0, ee_wr, ee_rd, tickle});
      $display("test control done");
   endtask : t_control

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_values();
      t_algo_and_params();
      t_meas_flags();
      t_status_writes();
      t_control();
      print_verdict();
   end
endmodule : tb_top
